// >>> tmr8_top.sv
`timescale 1ns/10ps
module tmr8_top (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        reset,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tmr8_pkg::ADDR_W-1:0] paddr,
    input  wire logic [tmr8_pkg::DATA_W-1:0] pwdata,
    output logic      [tmr8_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Count pin and CPU side
    input  wire logic                        ext_count_pin,
    input  wire logic                        global_irq_enable,
    input  wire logic [2:0]                  vector_ack,
    // Waveform outputs
    output logic                             wave_out_a,
    output logic                             wave_out_b,
    output logic                             wave_en_a,
    output logic                             wave_en_b,
    // Interrupt requests: bit 2 match B, 1 match A, 0 overflow
    output logic [2:0]                       irq_req
);
    import tmr8_pkg::*;

    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic        wgm_hi;
        logic [2:0]  cs;
        logic [7:0]  cnt;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic [2:0]  mask;
        logic [2:0]  flags;
        tmr8_dir_t   dir;
        logic        blk;
        logic        force_a;
        logic        force_b;
        logic        match_a;
        logic        match_b;
        logic        at_top;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
        logic [2:0]  irq;
        logic        en_a;
        logic        en_b;
    } tmr8_st_t;

    tmr8_st_t    st_r;
    tmr8_st_t    st_nxt;
    logic        tick;
    logic [2:0]  wgm;
    tmr8_class_t cls;
    logic [7:0]  top;
    logic [5:0]  idx;
    logic        hit;
    logic        acc;
    logic [2:0]  set_v;
    logic [2:0]  clr_v;
    logic [2:0]  wgm_new;
    logic [7:0]  rd_byte;
    logic [1:0]  match_v;
    logic [1:0]  force_v;
    logic [1:0]  mode_v [2];
    logic [1:0]  tog_v;
    logic [1:0]  wave_v;

    tmr8_ch_if ch [2] ();

    // Mode class of a waveform mode code
    function automatic tmr8_class_t mode_class(input logic [2:0] m);
        tmr8_class_t c;
        c = TMR8_NONPWM;
        if (m == WGM_FAST_FF || m == WGM_FAST_OCRA) begin
            c = TMR8_FAST;
        end else if (m == WGM_PC_FF || m == WGM_PC_OCRA) begin
            c = TMR8_PHASE;
        end
        return c;
    endfunction : mode_class

    // Timer clock source
    tmr8_clk_sel u_clk_sel (
        .mclk               (mclk),
        .reset              (reset),
        .clock_select_field (st_r.cs),
        .ext_count_pin      (ext_count_pin),
        .tick               (tick)
    );

    // Decode of mode, TOP and bus address
    always_comb begin
        wgm = {st_r.wgm_hi, st_r.ctrl_a[1:0]};
        cls = mode_class(wgm);
        top = CNT_MAX;
        if (wgm == WGM_CTC || wgm == WGM_PC_OCRA || wgm == WGM_FAST_OCRA) begin
            top = st_r.cmp_a;
        end
        idx = paddr[7:2];
        acc = psel & penable;
        hit = (paddr[1:0] == WORD_ALIGN)
            && (idx == IDX_CTRL_A || idx == IDX_CTRL_B || idx == IDX_CNT
             || idx == IDX_CMP_A || idx == IDX_CMP_B || idx == IDX_MASK
             || idx == IDX_FLAGS);
    end

    // Read multiplexer
    always_comb begin
        rd_byte = RESET_BYTE;
        unique case (idx)
            IDX_CTRL_A: rd_byte = st_r.ctrl_a;
            IDX_CTRL_B: rd_byte = {RD_ZERO4, st_r.wgm_hi, st_r.cs};
            IDX_CNT:    rd_byte = st_r.cnt;
            IDX_CMP_A:  rd_byte = st_r.cmp_a;
            IDX_CMP_B:  rd_byte = st_r.cmp_b;
            IDX_MASK:   rd_byte = {RD_ZERO5, st_r.mask};
            IDX_FLAGS:  rd_byte = {RD_ZERO5, st_r.flags};
            default:    rd_byte = RESET_BYTE;
        endcase
    end

    // Counter, flags and register updates
    always_comb begin
        st_nxt         = st_r;
        st_nxt.force_a = 1'b0;
        st_nxt.force_b = 1'b0;
        st_nxt.match_a = 1'b0;
        st_nxt.match_b = 1'b0;
        st_nxt.at_top  = 1'b0;
        set_v          = RESET_BITS3;
        clr_v          = RESET_BITS3;
        wgm_new        = {pwdata[CB_WGM_HI], st_r.ctrl_a[1:0]};

        if (tick) begin
            // Compare on the timer clock unless a counter write blocked it
            if (!st_r.blk) begin
                st_nxt.match_a = (st_r.cnt == st_r.cmp_a);
                st_nxt.match_b = (st_r.cnt == st_r.cmp_b);
            end
            set_v[BIT_MATCH_A] = st_nxt.match_a;
            set_v[BIT_MATCH_B] = st_nxt.match_b;
            st_nxt.blk = 1'b0;
            if (cls == TMR8_PHASE) begin
                if (st_r.dir == TMR8_UP) begin
                    if (st_r.cnt == top) begin
                        st_nxt.dir    = TMR8_DOWN;
                        st_nxt.cnt    = st_r.cnt - CNT_STEP;
                        st_nxt.at_top = 1'b1;
                    end else begin
                        st_nxt.cnt = st_r.cnt + CNT_STEP;
                    end
                end else if (st_r.cnt == CNT_BOTTOM) begin
                    st_nxt.dir       = TMR8_UP;
                    st_nxt.cnt       = st_r.cnt + CNT_STEP;
                    set_v[BIT_OVF]   = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_STEP;
                end
            end else begin
                st_nxt.dir = TMR8_UP;
                if (st_r.cnt == top || st_r.cnt == CNT_MAX) begin
                    st_nxt.cnt     = CNT_BOTTOM;
                    st_nxt.at_top  = 1'b1;
                    // Overflow at MAX, or at TOP in the OCRA fast mode
                    set_v[BIT_OVF] = (st_r.cnt == CNT_MAX)
                                   || (wgm == WGM_FAST_OCRA);
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_STEP;
                end
            end
        end

        // Bus answer one cycle into the access phase
        st_nxt.ready  = acc & ~st_r.ready;
        st_nxt.slverr = acc & ~st_r.ready & ~hit;
        if (acc && !st_r.ready) begin
            // Writes and refused reads return zero
            st_nxt.rdata = (pwrite || !hit) ? {RD_PAD, RESET_BYTE}
                                            : {RD_PAD, rd_byte};
        end

        // Writes take effect at the completing edge
        if (acc && st_r.ready && pwrite && hit) begin
            unique case (idx)
                IDX_CTRL_A: st_nxt.ctrl_a = pwdata[7:0] & CTRL_A_WMASK;
                IDX_CTRL_B: begin
                    st_nxt.wgm_hi = pwdata[CB_WGM_HI];
                    st_nxt.cs     = pwdata[2:0];
                    if (mode_class(wgm_new) == TMR8_NONPWM) begin
                        st_nxt.force_a = pwdata[CB_FORCE_A];
                        st_nxt.force_b = pwdata[CB_FORCE_B];
                    end
                end
                IDX_CNT: begin
                    st_nxt.cnt = pwdata[7:0];
                    st_nxt.blk = 1'b1;
                end
                IDX_CMP_A:  st_nxt.cmp_a = pwdata[7:0];
                IDX_CMP_B:  st_nxt.cmp_b = pwdata[7:0];
                IDX_MASK:   st_nxt.mask  = pwdata[2:0];
                IDX_FLAGS:  clr_v        = pwdata[2:0];
                default:    st_nxt.cmp_b = st_r.cmp_b;
            endcase
        end

        // Flags: set wins over a clear in the same cycle; forces never set
        st_nxt.flags = (st_r.flags & ~clr_v & ~vector_ack)
                     | set_v;
        st_nxt.irq   = st_r.mask & st_r.flags
                     & {3{global_irq_enable}};
        st_nxt.en_a  = st_r.ctrl_a[CA_OUT_A +: 2] != OM_OFF;
        st_nxt.en_b  = st_r.ctrl_a[CA_OUT_B +: 2] != OM_OFF;
    end

    // State register; everything clears so the timer starts stopped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Per-channel vectors for the waveform units
    assign match_v   = {st_r.match_b, st_r.match_a};
    assign force_v   = {st_r.force_b, st_r.force_a};
    assign mode_v[0] = st_r.ctrl_a[CA_OUT_A +: 2];
    assign mode_v[1] = st_r.ctrl_a[CA_OUT_B +: 2];
    assign tog_v     = {1'b0, st_r.wgm_hi};

    // Waveform output units, one per channel
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign ch[g].match     = match_v[g];
        assign ch[g].force_m   = force_v[g];
        assign ch[g].at_top    = st_r.at_top;
        assign ch[g].cls       = cls;
        assign ch[g].dir       = st_r.dir;
        assign ch[g].out_mode  = mode_v[g];
        assign ch[g].toggle_ok = tog_v[g];
        assign wave_v[g]       = ch[g].wave;
        tmr8_wave_unit u_wave (
            .mclk  (mclk),
            .reset (reset),
            .ch    (ch[g])
        );
    end

    // Outputs straight from flip-flops
    assign prdata     = st_r.rdata;
    assign pready     = st_r.ready;
    assign pslverr    = st_r.slverr;
    assign irq_req    = st_r.irq;
    assign wave_out_a = wave_v[0];
    assign wave_out_b = wave_v[1];
    assign wave_en_a  = st_r.en_a;
    assign wave_en_b  = st_r.en_b;
endmodule : tmr8_top

// >>> tmr8_pkg.sv
package tmr8_pkg;
    // Bus geometry
    localparam int           ADDR_W        = 8;
    localparam int           DATA_W        = 32;
    localparam logic [1:0]   WORD_ALIGN    = 2'h0;
    // Register indices; byte address is four times the index
    localparam logic [5:0]   IDX_CTRL_A    = 6'h24;
    localparam logic [5:0]   IDX_CTRL_B    = 6'h25;
    localparam logic [5:0]   IDX_CNT       = 6'h26;
    localparam logic [5:0]   IDX_CMP_A     = 6'h27;
    localparam logic [5:0]   IDX_CMP_B     = 6'h28;
    localparam logic [5:0]   IDX_MASK      = 6'h2E;
    localparam logic [5:0]   IDX_FLAGS     = 6'h15;
    // Field positions
    localparam int           CB_FORCE_A    = 7;
    localparam int           CB_FORCE_B    = 6;
    localparam int           CB_WGM_HI     = 3;
    localparam int           CA_OUT_A      = 6;
    localparam int           CA_OUT_B      = 4;
    localparam int           BIT_MATCH_B   = 2;
    localparam int           BIT_MATCH_A   = 1;
    localparam int           BIT_OVF       = 0;
    localparam logic [7:0]   CTRL_A_WMASK  = 8'hF3;
    // Reset values and counter limits
    localparam logic [7:0]   RESET_BYTE    = 8'h00;
    localparam logic [2:0]   RESET_BITS3   = 3'h0;
    localparam logic [7:0]   CNT_MAX       = 8'hFF;
    localparam logic [7:0]   CNT_BOTTOM    = 8'h00;
    localparam logic [7:0]   CNT_STEP      = 8'h01;
    localparam logic [23:0]  RD_PAD        = 24'h000000;
    localparam logic [3:0]   RD_ZERO4      = 4'h0;
    localparam logic [4:0]   RD_ZERO5      = 5'h00;
    // Clock select codes
    localparam logic [2:0]   CS_STOP       = 3'h0;
    localparam logic [2:0]   CS_DIV1       = 3'h1;
    localparam logic [2:0]   CS_DIV8       = 3'h2;
    localparam logic [2:0]   CS_DIV64      = 3'h3;
    localparam logic [2:0]   CS_DIV256     = 3'h4;
    localparam logic [2:0]   CS_DIV1024    = 3'h5;
    localparam logic [2:0]   CS_EXT_FALL   = 3'h6;
    localparam logic [2:0]   CS_EXT_RISE   = 3'h7;
    // Prescaler terminal masks
    localparam logic [9:0]   PRE_ONE       = 10'h001;
    localparam logic [9:0]   PRE_M8        = 10'h007;
    localparam logic [9:0]   PRE_M64       = 10'h03F;
    localparam logic [9:0]   PRE_M256      = 10'h0FF;
    localparam logic [9:0]   PRE_M1024     = 10'h3FF;
    // Waveform modes
    localparam logic [2:0]   WGM_NORMAL    = 3'h0;
    localparam logic [2:0]   WGM_PC_FF     = 3'h1;
    localparam logic [2:0]   WGM_CTC       = 3'h2;
    localparam logic [2:0]   WGM_FAST_FF   = 3'h3;
    localparam logic [2:0]   WGM_PC_OCRA   = 3'h5;
    localparam logic [2:0]   WGM_FAST_OCRA = 3'h7;
    // Compare output modes
    localparam logic [1:0]   OM_OFF        = 2'h0;
    localparam logic [1:0]   OM_TOGGLE     = 2'h1;
    localparam logic [1:0]   OM_CLEAR      = 2'h2;
    localparam logic [1:0]   OM_SET        = 2'h3;

    typedef enum logic [1:0] {
        TMR8_NONPWM = 2'b00,
        TMR8_FAST   = 2'b01,
        TMR8_PHASE  = 2'b11
    } tmr8_class_t;

    typedef enum logic {
        TMR8_UP   = 1'b0,
        TMR8_DOWN = 1'b1
    } tmr8_dir_t;
endpackage : tmr8_pkg

// >>> tmr8_ch_if.sv
`timescale 1ns/10ps
interface tmr8_ch_if;
    import tmr8_pkg::*;
    logic        match;
    logic        force_m;
    logic        at_top;
    tmr8_class_t cls;
    tmr8_dir_t   dir;
    logic [1:0]  out_mode;
    logic        toggle_ok;
    logic        wave;

    modport core (output match, force_m, at_top, cls, dir, out_mode,
                  toggle_ok, input wave);
    modport unit (input match, force_m, at_top, cls, dir, out_mode,
                  toggle_ok, output wave);
endinterface : tmr8_ch_if

// >>> tmr8_clk_sel.sv
`timescale 1ns/10ps
module tmr8_clk_sel (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Selection and pin
    input  wire logic [2:0] clock_select_field,
    input  wire logic       ext_count_pin,
    // Timer clock enable
    output logic            tick
);
    import tmr8_pkg::*;

    typedef struct packed {
        logic [9:0] presc;
        logic       s1;
        logic       s2;
        logic       s3;
        logic       tick;
    } tmr8_cs_st_t;

    tmr8_cs_st_t st_r;
    tmr8_cs_st_t st_nxt;

    // Prescaler, pin synchroniser and tick selection
    always_comb begin
        st_nxt       = st_r;
        st_nxt.presc = st_r.presc + PRE_ONE;
        st_nxt.s1    = ext_count_pin;
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        unique case (clock_select_field)
            CS_STOP:     st_nxt.tick = 1'b0;
            CS_DIV1:     st_nxt.tick = 1'b1;
            CS_DIV8:     st_nxt.tick = (st_r.presc & PRE_M8) == PRE_M8;
            CS_DIV64:    st_nxt.tick = (st_r.presc & PRE_M64) == PRE_M64;
            CS_DIV256:   st_nxt.tick = (st_r.presc & PRE_M256) == PRE_M256;
            CS_DIV1024:  st_nxt.tick = st_r.presc == PRE_M1024;
            CS_EXT_FALL: st_nxt.tick = st_r.s3 & ~st_r.s2;
            CS_EXT_RISE: st_nxt.tick = st_r.s2 & ~st_r.s3;
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule : tmr8_clk_sel

// >>> tmr8_wave_unit.sv
`timescale 1ns/10ps
module tmr8_wave_unit (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Channel link to the core
    tmr8_ch_if.unit   ch
);
    import tmr8_pkg::*;

    typedef struct packed {
        logic wave;
    } tmr8_wv_st_t;

    tmr8_wv_st_t st_r;
    tmr8_wv_st_t st_nxt;

    // Output level update per mode class
    always_comb begin
        st_nxt = st_r;
        unique case (ch.cls)
            TMR8_NONPWM: begin
                if (ch.match || ch.force_m) begin
                    unique case (ch.out_mode)
                        OM_OFF:    st_nxt.wave = st_r.wave;
                        OM_TOGGLE: st_nxt.wave = ~st_r.wave;
                        OM_CLEAR:  st_nxt.wave = 1'b0;
                        OM_SET:    st_nxt.wave = 1'b1;
                    endcase
                end
            end
            TMR8_FAST: begin
                if (ch.out_mode == OM_TOGGLE) begin
                    if (ch.toggle_ok && ch.match) begin
                        st_nxt.wave = ~st_r.wave;
                    end
                end else if (ch.out_mode[1]) begin
                    // TOP wins over a match landing at TOP
                    if (ch.at_top) begin
                        st_nxt.wave = (ch.out_mode == OM_CLEAR);
                    end else if (ch.match) begin
                        st_nxt.wave = (ch.out_mode == OM_SET);
                    end
                end
            end
            TMR8_PHASE: begin
                if (ch.out_mode == OM_TOGGLE) begin
                    if (ch.toggle_ok && ch.match) begin
                        st_nxt.wave = ~st_r.wave;
                    end
                end else if (ch.out_mode[1] && ch.match) begin
                    st_nxt.wave = (ch.out_mode == OM_SET)
                                ^ (ch.dir == TMR8_DOWN);
                end
            end
            default: st_nxt.wave = st_r.wave;
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.wave = st_r.wave;
endmodule : tmr8_wave_unit

// >>> tmr8_regs_props.sv
`timescale 1ns/10ps
module tmr8_regs_props (
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        reset,
    // Register bus
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic [tmr8_pkg::ADDR_W-1:0] paddr,
    input wire logic [tmr8_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Interrupt side
    input wire logic                        global_irq_enable,
    input wire logic [2:0]                  irq_req
);
    import tmr8_pkg::*;
    logic mapped;

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // Word index belongs to the register map
    assign mapped = paddr[7:2] inside {IDX_CTRL_A, IDX_CTRL_B, IDX_CNT,
        IDX_CMP_A, IDX_CMP_B, IDX_MASK, IDX_FLAGS};

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence

    a_answer_in_time: assert property (s_setup |-> ##[1:2] s_answer)
        else $error("bus access not answered in time");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_upper_read_zero: assert property (pready |-> prdata[31:8] == RD_PAD)
        else $error("upper read bits not zero");
    a_bad_addr_err: assert property (pready && (!mapped ||
        paddr[1:0] != WORD_ALIGN) |-> pslverr)
        else $error("bad address not refused");
    a_good_addr_ok: assert property (pready && mapped &&
        paddr[1:0] == WORD_ALIGN |-> !pslverr)
        else $error("mapped address refused");
    a_irq_global_gate: assert property (!global_irq_enable |=> irq_req == 3'h0)
        else $error("request without global enable");
    a_err_read_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
endmodule : tmr8_regs_props

bind tmr8_top tmr8_regs_props u_props (
    .mclk              (mclk),
    .reset             (reset),
    .psel              (psel),
    .penable           (penable),
    .paddr             (paddr),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .global_irq_enable (global_irq_enable),
    .irq_req           (irq_req)
);

// >>> tmr8_cpu_model.sv
`timescale 1ns/10ps
module tmr8_cpu_model (
    // Clock
    input  wire logic        mclk,
    // Bus requests
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // Bus answers
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // One transfer; request held until ready is seen at an edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
endmodule : tmr8_cpu_model

// >>> tmr8_top_tb_top.sv
`timescale 1ns/10ps
module tmr8_top_tb_top;
    import tmr8_pkg::*;
    localparam logic [7:0] A_CA = {IDX_CTRL_A, 2'h0};
    localparam logic [7:0] A_CB = {IDX_CTRL_B, 2'h0};
    localparam logic [7:0] A_CN = {IDX_CNT, 2'h0};
    localparam logic [7:0] A_MA = {IDX_CMP_A, 2'h0};
    localparam logic [7:0] A_MB = {IDX_CMP_B, 2'h0};
    localparam logic [7:0] A_IM = {IDX_MASK, 2'h0};
    localparam logic [7:0] A_IF = {IDX_FLAGS, 2'h0};
    logic        mclk = 1'b0, reset = 1'b1, pin = 1'b0, gie = 1'b0, e, bf;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        woa, wob, wea, web;
    logic [2:0]  ack = 3'h0, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  modes [3] = '{8'h40, 8'h80, 8'hC0};
    int          fail_count = 0, n_checks = 0, cyc = 0;

    // Clock and device
    always #12.5 mclk = ~mclk;
    tmr8_top uut (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(pin), .global_irq_enable(gie),
        .vector_ack(ack), .wave_out_a(woa), .wave_out_b(wob),
        .wave_en_a(wea), .wave_en_b(web), .irq_req(irq));
    tmr8_cpu_model cpu (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask : wr
    task rd(input logic [7:0] a);
        cpu.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    // Full pulses on the count pin, then room for synchronising
    task pulse(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (4) @(posedge mclk);
            pin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
    endtask : pulse

    task t_regs;
        rd(A_CB); chk(q, 32'h0);
        rd(A_MA); chk(q, 32'h0);
        wr(A_MA, 8'hA5); rd(A_MA); chk(q, 32'hA5);
        wr(A_MB, 8'h5A); rd(A_MB); chk(q, 32'h5A);
        wr(A_IM, 8'hFF); rd(A_IM); chk(q, 32'h07);
        wr(A_CB, 8'hF0); rd(A_CB); chk(q, 32'h0);
        rd(8'hFC); chk({31'h0, e}, 32'h1);
        rd(A_CN + 8'h01); chk({31'h0, e}, 32'h1);
    endtask : t_regs

    task t_count;
        wr(A_CN, 8'h10); wr(A_CB, {5'h0, CS_EXT_RISE}); pulse(3);
        rd(A_CN); chk(q, 32'h13);
        wr(A_CB, {5'h0, CS_EXT_FALL}); pulse(2);
        rd(A_CN); chk(q, 32'h15);
        wr(A_CB, {5'h0, CS_STOP}); pulse(2);
        rd(A_CN); chk(q, 32'h15);
    endtask : t_count

    task t_flags;
        wr(A_IF, 8'h07); wr(A_MA, 8'h01); wr(A_MB, 8'h40);
        wr(A_CN, 8'hFE); wr(A_CB, {5'h0, CS_EXT_RISE}); pulse(2);
        rd(A_IF); chk(q, 32'h01);
        gie <= 1'b1; repeat (3) @(posedge mclk);
        chk({29'h0, irq}, 32'h1);
        pulse(2); rd(A_IF); chk(q, 32'h03);
        wr(A_IF, 8'h01); rd(A_IF); chk(q, 32'h02);
        ack <= 3'h2; @(posedge mclk); ack <= 3'h0;
        rd(A_IF); chk(q, 32'h0);
        gie <= 1'b0; repeat (3) @(posedge mclk);
        chk({29'h0, irq}, 32'h0);
        wr(A_CN, 8'h01); pulse(2);
        rd(A_IF); chk(q, 32'h0);
        wr(A_MB, 8'h05); pulse(4);
        rd(A_IF); chk(q, 32'h04);
        wr(A_CB, 8'h00); wr(A_IF, 8'h07);
    endtask : t_flags

    task t_force;
        for (int i = 0; i < 3; i++) begin
            wr(A_CA, modes[i]);
            bf = woa;
            wr(A_CB, 8'h80); repeat (3) @(posedge mclk);
            chk({31'h0, woa}, {31'h0, (i == 0) ? ~bf : (i == 2)});
            chk({31'h0, wea}, 32'h1);
        end
        wr(A_CA, 8'h10); bf = wob;
        wr(A_CB, 8'h40); repeat (3) @(posedge mclk);
        chk({31'h0, wob}, {31'h0, ~bf});
        chk({31'h0, web}, 32'h1);
        rd(A_IF); chk(q, 32'h0);
        wr(A_CA, 8'h83);
        wr(A_CB, 8'h80); repeat (3) @(posedge mclk);
        chk({31'h0, woa}, 32'h1);
        wr(A_CB, 8'h00);
        chk({31'h0, woa}, 32'h1);
    endtask : t_force

    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            report_and_stop;
        end
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({29'h0, irq}, 32'h0);
        t_regs;
        t_count;
        t_flags;
        t_force;
        report_and_stop;
    end
endmodule : tmr8_top_tb_top
